// *** logic/axfp_framer.sv ***
// AX.25 link framer with APB registers, link timers and interrupt.
`timescale 1ns/1ps

// Overview of operation
// - Connectionless traffic uses UI frames with the ordinary frame layout.
// - With filtering on, only UI frames whose destination matches the code word pass.
// - Frames must carry a full source address after the destination.
// - Bad connectionless frames are dropped; no retransmission is ever requested.
// - T1 is never shorter than a floor covering twice a long round trip.
// - T2 runs only while T1 is idle; its expiry asks for a supervisory frame.
// - Retry limit N2 is software set and defaults to sixteen.
// - Information field holds at most 256 octets.
// - Information field length should be even.
// - At most seven unacknowledged information frames are outstanding.
// - A smaller agreed window may be set by software.
// - Order is flag, address, control, check sequence, flag.
// - Information frames add protocol byte and information before the check sequence.
// - Reaching N2 retries abandons recovery and signals link reset.
module axfp_framer #(
  parameter int BIT_CYCLES  = axfp_pkg::BIT_CYC,
  parameter int TICK_CYCLES = axfp_pkg::TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_data,
  input  wire logic        rx_clk,
  output logic             tx_data,
  output logic             tx_key,
  output logic             irq
);
  import axfp_pkg::*;

  typedef struct packed {
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    logic            tx_en;
    logic            filt_en;
    logic [7:0]      ist;
    logic [7:0]      msk;
    logic            irq;
    logic [15:0]     t1v;
    logic [15:0]     t2v;
    logic [4:0]      n2;
    logic [2:0]      kw;
    logic [5:0][7:0] filt;
    logic [15:0]     bdiv;
    logic [15:0]     tdiv;
    axfp_tx_t        txs;
    logic [15:0]     tsh;
    logic [4:0]      tbits;
    logic [2:0]      tones;
    logic [15:0]     tcrc;
    logic [7:0]      hold;
    logic            hold_v;
    logic            hold_last;
    logic            cur_last;
    logic [1:0]      tsec;
    logic [3:0]      taidx;
    logic            tinfo_fr;
    logic            tiframe;
    logic            tabort;
    logic [9:0]      tinfo;
    logic            tx_data;
    logic            tx_key;
    logic            rs1;
    logic            rs2;
    logic            cs1;
    logic            cs2;
    logic            cs3;
    logic [7:0]      rsh;
    logic [2:0]      rones;
    logic            rin;
    logic [2:0]      rbcnt;
    logic [7:0]      racc;
    logic [15:0]     rcrc;
    logic [1:0]      rsec;
    logic [3:0]      raidx;
    logic            rmatch;
    logic            rui;
    logic            rinfo_fr;
    logic            rbad;
    logic [9:0]      rinfo;
    logic [7:0]      rd_byte;
    logic            rd_v;
    logic            rd_first;
    logic            t1_run;
    logic [15:0]     t1c;
    logic [15:0]     t2c;
    logic [2:0]      outn;
    logic [4:0]      retry;
  } axfp_st_t;

  axfp_st_t    r;
  axfp_st_t    next_r;
  logic [7:0]  ev;
  logic [7:0]  clr;
  logic [7:0]  sh8;
  logic [7:0]  ld;
  logic [15:0] t1eff;
  logic        bit_en;
  logic        tick;
  logic        rbit;
  logic        acc;
  logic        com;
  logic        need;
  logic        abt;
  logic        take;
  logic        fin;

  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
    crc_bit = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
  endfunction : crc_bit

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c;
    for (int i = 0; i < 8; i++) x = crc_bit(x, d[i]);
    crc_byte = x;
  endfunction : crc_byte

  always_comb begin
    next_r = r;
    ev = 8'h00;
    clr = 8'h00;
    sh8 = 8'h00;
    ld = 8'h00;
    need = 1'b0;
    abt = 1'b0;
    take = 1'b0;
    fin = 1'b0;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    next_r.rs1 = rx_data;
    next_r.rs2 = r.rs1;
    next_r.cs1 = rx_clk;
    next_r.cs2 = r.cs1;
    next_r.cs3 = r.cs2;
    bit_en = r.bdiv == 16'(BIT_CYCLES - 1);
    next_r.bdiv = bit_en ? 16'h0000 : r.bdiv + 16'h0001;
    tick = r.tdiv == 16'(TICK_CYCLES - 1);
    next_r.tdiv = tick ? 16'h0000 : r.tdiv + 16'h0001;
    rbit = r.cs2 & ~r.cs3;
    t1eff = (r.t1v < T1_MIN) ? T1_MIN : r.t1v;
    acc = psel & penable & ~r.pready;
    com = psel & penable & r.pready;

    // Access phase: answer one cycle later with registered data.
    if (acc) begin
      next_r.pready = 1'b1;
      next_r.prdata = 32'h0000_0000;
      case (paddr)
        A_CTRL: next_r.prdata = 32'({r.filt_en, r.tx_en});
        A_STAT: next_r.prdata = 32'({r.retry, 3'h0, r.outn, r.t1_run, r.rin, r.tx_key,
                                     ~r.hold_v});
        A_IST:  next_r.prdata = 32'(r.ist);
        A_MSK:  next_r.prdata = 32'(r.msk);
        A_TXD:  next_r.pslverr = pwrite & r.hold_v;
        A_RXD: begin
          next_r.prdata = 32'({r.rd_first, r.rd_v, r.rd_byte});
          if (!pwrite) next_r.rd_v = 1'b0;
        end
        A_T1:   next_r.prdata = 32'(r.t1v);
        A_T2:   next_r.prdata = 32'(r.t2v);
        A_CFG:  next_r.prdata = 32'({r.kw, 3'h0, r.n2});
        A_ACK:  next_r.prdata = 32'h0000_0000;
        A_FLO:  next_r.prdata = r.filt[3:0];
        A_FHI:  next_r.prdata = 32'(r.filt[5:4]);
        default: next_r.pslverr = 1'b1;
      endcase
    end

    // Writes take effect on the edge that completes the transfer.
    if (com && pwrite && !r.pslverr) begin
      case (paddr)
        A_CTRL: begin
          next_r.tx_en = pwdata[CTRL_TX_EN];
          next_r.filt_en = pwdata[CTRL_FILT];
        end
        A_IST: clr = pwdata[7:0];
        A_MSK: next_r.msk = pwdata[7:0];
        A_TXD: begin
          if (r.txs != TX_IDLE || (pwdata[TXD_START] && r.tx_en)) begin
            next_r.hold = pwdata[7:0];
            next_r.hold_v = 1'b1;
            next_r.hold_last = pwdata[TXD_LAST];
          end
          if (pwdata[TXD_START] && r.txs == TX_IDLE && r.tx_en) begin
            next_r.txs = TX_OPEN;
            next_r.tsh = 16'(FLAG);
            next_r.tbits = 5'h08;
            next_r.tcrc = CRC_INIT;
            next_r.tsec = 2'h0;
            next_r.taidx = 4'h0;
            next_r.tinfo = 10'h000;
            next_r.tinfo_fr = 1'b0;
            next_r.tiframe = 1'b0;
            next_r.tabort = 1'b0;
            next_r.tx_key = 1'b1;
          end
        end
        A_T1: next_r.t1v = pwdata[15:0];
        A_T2: next_r.t2v = pwdata[15:0];
        A_CFG: begin
          next_r.n2 = pwdata[4:0];
          next_r.kw = (pwdata[10:8] == 3'h0) ? K_MAX : pwdata[10:8];
        end
        A_ACK: begin
          next_r.outn = (pwdata[2:0] >= r.outn) ? 3'h0 : r.outn - pwdata[2:0];
          next_r.retry = 5'h00;
          if (next_r.outn == 3'h0) next_r.t1_run = 1'b0;
        end
        A_FLO: next_r.filt[3:0] = pwdata;
        A_FHI: next_r.filt[5:4] = pwdata[15:0];
        default: ;
      endcase
    end

    // Transmit serializer, one bit per bit-rate enable.
    if (bit_en) begin
      if (r.txs == TX_IDLE) begin
        next_r.tx_data = 1'b1;
        next_r.tx_key = next_r.txs != TX_IDLE;
      end else if (r.tones == STUFF_RUN) begin
        next_r.tx_data = 1'b0;
        next_r.tones = 3'h0;
      end else begin
        next_r.tx_data = r.tsh[0];
        next_r.tsh = r.tsh >> 1;
        next_r.tbits = r.tbits - 5'h01;
        if (r.txs == TX_DATA || r.txs == TX_FCS) begin
          next_r.tones = r.tsh[0] ? r.tones + 3'h1 : 3'h0;
        end
        if (r.txs == TX_DATA) next_r.tcrc = crc_bit(r.tcrc, r.tsh[0]);
        if (r.tbits == 5'h01) begin
          unique case (r.txs)
            TX_OPEN: need = 1'b1;
            TX_DATA: begin
              if (!r.cur_last) begin
                need = 1'b1;
              end else if (r.tsec < 2'h2 || (r.tinfo_fr && r.tsec == 2'h2)) begin
                abt = 1'b1;
              end else begin
                next_r.txs = TX_FCS;
                next_r.tsh = ~crc_bit(r.tcrc, r.tsh[0]);
                next_r.tbits = 5'h10;
                if (r.tinfo_fr && r.tinfo[0]) ev[EV_TXERR] = 1'b1;
              end
            end
            TX_FCS: begin
              next_r.txs = TX_CLOSE;
              next_r.tsh = 16'(FLAG);
              next_r.tbits = 5'h08;
            end
            TX_CLOSE: begin
              next_r.txs = TX_IDLE;
              next_r.hold_v = 1'b0;
              next_r.tones = 3'h0;
              ev[EV_TXDONE] = 1'b1;
              if (r.tiframe && !r.tabort) begin
                next_r.outn = next_r.outn + 3'h1;
                next_r.t1_run = 1'b1;
                next_r.t1c = 16'h0000;
              end
            end
            TX_IDLE: ;
          endcase
        end
      end
    end

    // Load the next octet and police the frame layout as it goes out.
    if (need) begin
      ld = r.hold;
      if (!r.hold_v) begin
        abt = 1'b1;
      end else begin
        next_r.hold_v = 1'b0;
        next_r.cur_last = r.hold_last;
        next_r.txs = TX_DATA;
        next_r.tsh = 16'(r.hold);
        next_r.tbits = 5'h08;
        unique case (r.tsec)
          2'h0: begin
            if (r.taidx != 4'hf) next_r.taidx = r.taidx + 4'h1;
            if (ld[0]) begin
              next_r.tsec = 2'h1;
              if (r.taidx < ADDR_LAST) abt = 1'b1;
            end
          end
          2'h1: begin
            next_r.tsec = 2'h2;
            next_r.tiframe = ~ld[0];
            next_r.tinfo_fr = ~ld[0] | ((ld & UI_MASK) == UI_CODE);
            if (~ld[0] && r.outn >= r.kw) abt = 1'b1;
          end
          2'h2: next_r.tsec = 2'h3;
          2'h3: begin
            next_r.tinfo = r.tinfo + 10'h001;
            if (r.tinfo_fr && r.tinfo >= N1_MAX) abt = 1'b1;
          end
        endcase
      end
    end
    if (abt) begin
      next_r.tabort = 1'b1;
      next_r.txs = TX_CLOSE;
      next_r.tsh = 16'(FLAG);
      next_r.tbits = 5'h08;
      ev[EV_TXERR] = 1'b1;
    end

    // Receive deframer on each rising edge of the synchronised bit clock.
    if (rbit) begin
      sh8 = {r.rs2, r.rsh[7:1]};
      next_r.rsh = sh8;
      if (sh8 == FLAG) begin
        fin = r.rin && r.rbcnt == 3'h7 && r.rsec == 2'h3;
        next_r.rin = 1'b1;
        next_r.rones = 3'h0;
        next_r.rbcnt = 3'h0;
        next_r.rcrc = CRC_INIT;
        next_r.rsec = 2'h0;
        next_r.raidx = 4'h0;
        next_r.rmatch = 1'b1;
        next_r.rui = 1'b0;
        next_r.rinfo_fr = 1'b0;
        next_r.rbad = 1'b0;
        next_r.rinfo = 10'h000;
      end else if (r.rs2) begin
        if (r.rones == 3'h6) begin
          next_r.rin = 1'b0;
        end else begin
          next_r.rones = r.rones + 3'h1;
          take = 1'b1;
        end
      end else if (r.rones == STUFF_RUN) begin
        next_r.rones = 3'h0;
      end else begin
        next_r.rones = 3'h0;
        take = 1'b1;
      end
      if (take && r.rin) begin
        ld = {r.rs2, r.racc[7:1]};
        next_r.racc = ld;
        next_r.rbcnt = r.rbcnt + 3'h1;
        if (r.rbcnt == 3'h7) begin
          next_r.rcrc = crc_byte(r.rcrc, ld);
          if (!r.filt_en || r.rmatch) begin
            if (next_r.rd_v) ev[EV_OVR] = 1'b1;
            next_r.rd_byte = ld;
            next_r.rd_v = 1'b1;
            next_r.rd_first = r.rsec == 2'h0 && r.raidx == 4'h0;
          end
          unique case (r.rsec)
            2'h0: begin
              if (r.raidx < 4'h6 && ld != r.filt[r.raidx[2:0]]) next_r.rmatch = 1'b0;
              if (r.raidx != 4'hf) next_r.raidx = r.raidx + 4'h1;
              if (ld[0]) begin
                next_r.rsec = 2'h1;
                if (r.raidx < ADDR_LAST) next_r.rbad = 1'b1;
              end
            end
            2'h1: begin
              next_r.rsec = 2'h2;
              next_r.rui = (ld & UI_MASK) == UI_CODE;
              next_r.rinfo_fr = ~ld[0] | ((ld & UI_MASK) == UI_CODE);
            end
            2'h2: next_r.rsec = 2'h3;
            2'h3: if (r.rinfo_fr && r.rinfo != 10'h3ff) next_r.rinfo = r.rinfo + 10'h001;
          endcase
        end
      end
      if (fin) begin
        if (r.rcrc == CRC_GOOD && !r.rbad && (!r.filt_en || (r.rmatch && r.rui))
            && !(r.rinfo_fr && (r.rinfo > N1_FCS || r.rinfo[0]))) begin
          ev[EV_RXOK] = 1'b1;
        end else begin
          ev[EV_RXDROP] = 1'b1;
        end
      end
    end

    // Link timers on the slow tick.
    if (tick) begin
      if (r.t1_run) begin
        next_r.t2c = 16'h0000;
        if (r.t1c >= t1eff - 16'h0001) begin
          next_r.t1c = 16'h0000;
          if (r.retry + 5'h01 >= r.n2) begin
            next_r.t1_run = 1'b0;
            next_r.retry = 5'h00;
            next_r.outn = 3'h0;
            ev[EV_LRST] = 1'b1;
          end else begin
            next_r.retry = r.retry + 5'h01;
            ev[EV_T1] = 1'b1;
          end
        end else begin
          next_r.t1c = r.t1c + 16'h0001;
        end
      end else if (r.tx_en) begin
        if (r.t2c >= r.t2v - 16'h0001) begin
          next_r.t2c = 16'h0000;
          ev[EV_T2] = 1'b1;
        end else begin
          next_r.t2c = r.t2c + 16'h0001;
        end
      end
    end

    next_r.ist = (r.ist & ~clr) | ev;
    next_r.irq = |(next_r.ist & next_r.msk);

    if (sys_rst) begin
      next_r = '0;
      next_r.txs = TX_IDLE;
      next_r.tx_data = 1'b1;
      next_r.t1v = T1_DEF;
      next_r.t2v = T2_DEF;
      next_r.n2 = N2_DEF;
      next_r.kw = K_MAX;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign prdata  = r.prdata;
  assign pready  = r.pready;
  assign pslverr = r.pslverr;
  assign tx_data = r.tx_data;
  assign tx_key  = r.tx_key;
  assign irq     = r.irq;
endmodule : axfp_framer

// *** logic/axfp_pkg.sv ***
// Constants and types shared by the AX.25 link framer.
package axfp_pkg;
  localparam int          CLK_HZ      = 40_000_000;
  localparam int          BIT_RATE    = 1200;
  localparam int          BIT_CYC     = CLK_HZ / BIT_RATE;
  localparam int          TICK_US     = 1000;
  localparam int          TICK_CYC    = CLK_HZ / 1_000_000 * TICK_US;
  localparam logic [7:0]  FLAG        = 8'h7e;
  localparam logic [15:0] CRC_INIT    = 16'hffff;
  localparam logic [15:0] CRC_POLY    = 16'h8408;
  localparam logic [15:0] CRC_GOOD    = 16'hf0b8;
  localparam logic [7:0]  UI_MASK     = 8'hef;
  localparam logic [7:0]  UI_CODE     = 8'h03;
  localparam logic [9:0]  N1_MAX      = 10'h100;
  localparam logic [9:0]  N1_FCS      = 10'h102;
  localparam logic [2:0]  K_MAX       = 3'h7;
  localparam logic [4:0]  N2_DEF      = 5'h10;
  localparam logic [15:0] T1_DEF      = 16'h0bb8;
  localparam logic [15:0] T1_MIN      = 16'h0064;
  localparam logic [15:0] T2_DEF      = 16'h2710;
  localparam logic [2:0]  STUFF_RUN   = 3'h5;
  localparam logic [3:0]  ADDR_LAST   = 4'hd;
  localparam logic [7:0]  A_CTRL      = 8'h00;
  localparam logic [7:0]  A_STAT      = 8'h04;
  localparam logic [7:0]  A_IST       = 8'h08;
  localparam logic [7:0]  A_MSK       = 8'h0c;
  localparam logic [7:0]  A_TXD       = 8'h10;
  localparam logic [7:0]  A_RXD       = 8'h14;
  localparam logic [7:0]  A_T1        = 8'h18;
  localparam logic [7:0]  A_T2        = 8'h1c;
  localparam logic [7:0]  A_CFG       = 8'h20;
  localparam logic [7:0]  A_ACK       = 8'h24;
  localparam logic [7:0]  A_FLO       = 8'h28;
  localparam logic [7:0]  A_FHI       = 8'h2c;
  localparam int          CTRL_TX_EN  = 0;
  localparam int          CTRL_FILT   = 1;
  localparam int          TXD_START   = 8;
  localparam int          TXD_LAST    = 9;
  localparam int          EV_TXDONE   = 0;
  localparam int          EV_TXERR    = 1;
  localparam int          EV_RXOK     = 2;
  localparam int          EV_RXDROP   = 3;
  localparam int          EV_T1       = 4;
  localparam int          EV_T2       = 5;
  localparam int          EV_LRST     = 6;
  localparam int          EV_OVR      = 7;

  typedef enum logic [2:0] {TX_IDLE, TX_OPEN, TX_DATA, TX_FCS, TX_CLOSE} axfp_tx_t;
endpackage : axfp_pkg

// *** sim/axfp_chk.sv ***
// Port-level assertions for the AX.25 link framer.
`timescale 1ns/1ps
module axfp_chk #(
  parameter int BIT_CYCLES  = 4,
  parameter int TICK_CYCLES = 8
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_data,
  input wire logic        rx_clk,
  input wire logic        tx_data,
  input wire logic        tx_key,
  input wire logic        irq
);
  import axfp_pkg::*;
  int run;
  int hi;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Counts cycles since the line last changed and the length of a run of ones.
  always_ff @(posedge clk) begin
    run <= (sys_rst || $changed(tx_data)) ? 1 : run + 1;
    hi  <= (!sys_rst && tx_key && tx_data) ? hi + 1 : 0;
  end
  property p_rdy_once;
    pready |=> !pready;
  endproperty
  a_rdy_once: assert property (p_rdy_once) else $error("pready held too long");
  property p_rdy_time;
    psel && penable && !pready |=> pready;
  endproperty
  a_rdy_time: assert property (p_rdy_time) else $error("pready late");
  property p_rdy_cause;
    pready |-> $past(psel && penable);
  endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("pready without request");
  property p_err_zero;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("bad error response");
  property p_unmapped;
    psel && penable && !pready && paddr > A_FHI |=> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  property p_rst_out;
    $fell(sys_rst) |-> !tx_key && tx_data && !irq && !pready;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not at reset level");
  property p_idle_one;
    (!tx_key) [*2] |-> tx_data;
  endproperty
  a_idle_one: assert property (p_idle_one) else $error("line not idle high");
  property p_bit_len;
    tx_key && $changed(tx_data) |-> run >= BIT_CYCLES;
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit shorter than one period");
  property p_ones;
    hi <= 6 * BIT_CYCLES;
  endproperty
  a_ones: assert property (p_ones) else $error("more than six ones in a row");
  c_frame: cover property ($rose(tx_key));
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
endmodule : axfp_chk

bind axfp_framer axfp_chk #(.BIT_CYCLES(BIT_CYCLES), .TICK_CYCLES(TICK_CYCLES)) chk_u (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_data(rx_data), .rx_clk(rx_clk), .tx_data(tx_data), .tx_key(tx_key), .irq(irq)
);

// *** sim/axfp_framer_test.sv ***
// Self-checking bench for the AX.25 link framer.
`timescale 1ns/1ps
module axfp_framer_test;
  import axfp_pkg::*;
  typedef struct packed {logic er; logic [31:0] e; logic [31:0] m;} axfp_note_t;
  localparam logic [31:0] RV [9] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'hbb8,
                                     32'h2710, 32'h710};
  logic       clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic       rx_data, rx_clk, tx_data, tx_key, irq;
  logic [7:0] paddr, a;
  logic [31:0] pwdata, prdata, last_rd;
  logic [7:0] fr[$];
  logic [7:0] dst[6];
  axfp_note_t notes[$];
  int         errors = 0;
  int         total_checks = 0;
  int         n0;
  axfp_framer #(.BIT_CYCLES(4), .TICK_CYCLES(8)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_data(rx_data), .rx_clk(rx_clk), .tx_data(tx_data), .tx_key(tx_key), .irq(irq)
  );
  axfp_peer #(.BIT_CYCLES(4)) peer_u (
    .clk(clk), .tx_data(tx_data), .tx_key(tx_key), .rx_data(rx_data), .rx_clk(rx_clk)
  );
  always #12.5 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // Compares each completed transfer with the oldest note.
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      chk("pslverr", {31'h0, pslverr}, {31'h0, notes[0].er});
      chk("prdata", prdata & notes[0].m, notes[0].e & notes[0].m);
      void'(notes.pop_front());
    end
  end
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d,
                      input logic er, input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{er, e, m});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (int i = 0; i <= 20; i++) begin
      if (i == 20) begin
        errors++;
        give_verdict();
      end
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    last_rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d, 1'b0, 32'h0, 32'h0);
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, ad, 32'h0, 1'b0, e, m);
  endtask : rd
  task automatic poll(input logic [7:0] ad, input logic [31:0] m);
    for (int i = 0; i <= 2000; i++) begin
      if (i == 2000) begin
        errors++;
        give_verdict();
      end
      rd(ad, 32'h0, 32'h0);
      if ((last_rd & m) !== 32'h0) break;
    end
  endtask : poll
  task automatic txf(input int n, input logic [7:0] ctl);
    logic [7:0] o;
    for (int i = 0; i < n; i++) begin
      o = 8'($urandom);
      if (i < 14) o[0] = (i == 13);
      if (i == 14) o = ctl;
      if (i == 15) o = 8'hf0;
      if (i > 0) poll(A_STAT, 32'h1);
      wr(A_TXD, {22'h0, i == n - 1, i == 0, o});
    end
    poll(A_IST, 32'h1);
  endtask : txf
  task automatic rxf(input logic [7:0] ctl, input logic bad, input logic [7:0] x,
                     input logic [31:0] e);
    logic [7:0] o;
    fr = {};
    for (int i = 0; i < 18; i++) begin
      o = (i < 6) ? dst[i] ^ ((i == 0) ? x : 8'h00) : 8'($urandom);
      if (i < 14) o[0] = (i == 13);
      if (i == 14) o = ctl;
      if (i == 15) o = 8'hf0;
      fr.push_back(o);
    end
    wr(A_IST, 32'hff);
    peer_u.send_frame(fr, bad);
    poll(A_IST, 32'hc);
    rd(A_IST, e, 32'hc);
    chk("irq", {31'h0, irq}, {31'h0, e == 32'h4});
  endtask : rxf
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(95279));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 9; i++) rd(8'(4 * i), RV[i], 32'hffffffff);
    a = 8'h30 + 8'(4 * $urandom_range(51, 0));
    xfer(1'b0, a, 32'h0, 1'b1, 32'h0, 32'hffffffff);
    xfer(1'b1, a, 32'($urandom), 1'b1, 32'h0, 32'h0);
    $display("registers done");
    wr(A_T2, 32'h3);
    wr(A_MSK, 32'h20);
    wr(A_CTRL, 32'h1);
    poll(A_IST, 32'h20);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(A_T2, 32'hffff);
    wr(A_IST, 32'h20);
    rd(A_IST, 32'h0, 32'h20);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("interrupt done");
    wr(A_T1, 32'h1);
    wr(A_CFG, 32'h102);
    wr(A_IST, 32'hff);
    txf(20, 8'h00);
    chk("open flag", {24'h0, peer_u.first_oct}, {24'h0, FLAG});
    rd(A_IST, 32'h1, 32'h3);
    rd(A_STAT, 32'h18, 32'h78);
    wr(A_T2, 32'h3);
    wr(A_IST, 32'hff);
    repeat (300) @(posedge clk);
    rd(A_IST, 32'h0, 32'h30);
    txf(20, 8'h00);
    rd(A_IST, 32'h3, 32'h3);
    poll(A_IST, 32'h40);
    rd(A_IST, 32'h10, 32'h10);
    rd(A_STAT, 32'h0, 32'h1f78);
    wr(A_IST, 32'hff);
    txf(19, UI_CODE);
    rd(A_IST, 32'h3, 32'h3);
    $display("transmit done");
    wr(A_T2, 32'hffff);
    wr(A_MSK, 32'h4);
    for (int i = 0; i < 6; i++) dst[i] = {7'($urandom), 1'b0};
    wr(A_FLO, {dst[3], dst[2], dst[1], dst[0]});
    wr(A_FHI, {16'h0, dst[5], dst[4]});
    wr(A_CTRL, 32'h3);
    n0 = peer_u.n_tx;
    rxf(UI_CODE, 1'b0, 8'h00, 32'h4);
    rxf(UI_CODE, 1'b1, 8'h00, 32'h8);
    rxf(UI_CODE, 1'b0, 8'h02, 32'h8);
    rxf(8'h00, 1'b0, 8'h00, 32'h8);
    wr(A_CTRL, 32'h1);
    rxf(UI_CODE, 1'b0, 8'h02, 32'h4);
    chk("peer frames", 32'(peer_u.n_tx), 32'(n0));
    $display("receive done");
    give_verdict();
  end
endmodule : axfp_framer_test

// *** sim/axfp_peer.sv ***
// Peer station model that sends frames to the framer and watches its line.
`timescale 1ns/1ps
module axfp_peer #(
  parameter int BIT_CYCLES = 4
) (
  input  wire logic clk,
  input  wire logic tx_data,
  input  wire logic tx_key,
  output logic      rx_data,
  output logic      rx_clk
);
  import axfp_pkg::*;
  logic [7:0]  first_oct = 8'h00;
  logic [15:0] crc;
  int          n_tx = 0;
  int          ones;
  initial begin
    rx_data = 1'b0;
    rx_clk = 1'b0;
  end
  // Samples the opening octet of each frame in the middle of each bit.
  always @(posedge tx_key) begin
    n_tx = n_tx + 1;
    @(negedge tx_data);
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      first_oct[i] = tx_data;
      repeat (BIT_CYCLES) @(posedge clk);
    end
  end
  task automatic put_bit(input logic b);
    rx_data <= b;
    repeat (BIT_CYCLES * 2) @(posedge clk);
    rx_clk <= 1'b1;
    repeat (BIT_CYCLES * 2) @(posedge clk);
    rx_clk <= 1'b0;
  endtask : put_bit
  task automatic put_oct(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      put_bit(v[i]);
      ones = v[i] ? ones + 1 : 0;
      if (ones == 5) begin
        put_bit(1'b0);
        ones = 0;
      end
    end
  endtask : put_oct
  task automatic send_frame(input logic [7:0] q[$], input logic bad);
    crc = CRC_INIT;
    ones = 0;
    for (int i = 0; i < 8; i++) put_bit(FLAG[i]);
    foreach (q[j]) begin
      put_oct(q[j]);
      for (int i = 0; i < 8; i++) crc = (crc >> 1) ^ ((crc[0] ^ q[j][i]) ? CRC_POLY : 16'h0);
    end
    crc = ~crc ^ {15'h0, bad};
    put_oct(crc[7:0]);
    put_oct(crc[15:8]);
    for (int i = 0; i < 8; i++) put_bit(FLAG[i]);
    rx_data <= ~rx_data;
  endtask : send_frame
endmodule : axfp_peer
